// *** verilog/mie_pkg.sv ***
package mie_pkg;
  // ==========================================================
  // register map (word index on ADDR)
  localparam logic [2:0] OFS_CTRL = 3'h0;
  localparam logic [2:0] OFS_PFLAG1 = 3'h1;
  localparam logic [2:0] OFS_PFLAG2 = 3'h2;
  localparam logic [2:0] OFS_PEN1 = 3'h3;
  localparam logic [2:0] OFS_PEN2 = 3'h4;
  localparam logic [2:0] OFS_EVT_STAT = 3'h5;
  localparam logic [2:0] OFS_EVT_MASK = 3'h6;

  // ==========================================================
  // irq_control_register fields
  localparam int CTRL_GIE_BIT = 7;
  localparam int CTRL_PERIPHERAL_GROUP_IRQ_ENABLE_BIT = 6;
  localparam int CTRL_EN_LSB = 3;
  localparam int CTRL_FLAG_LSB = 0;
  localparam int NUM_CORE_SRC = 3;
  localparam int NUM_PERIPH = 8;

  // ==========================================================
  // event status / mask fields
  localparam int EVT_W = 3;
  localparam int EVT_ENTRY = 0;
  localparam int EVT_RETURN = 1;
  localparam int EVT_HELD = 2;

  // ==========================================================
  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] PREG_RST = 8'h00;
  localparam logic [EVT_W-1:0] EVT_RST = 3'h0;

  // ==========================================================
  // core side constants and timing
  localparam int PC_W = 15;
  localparam logic [PC_W-1:0] VECTOR_ADDR = 15'h0004;
  localparam logic [1:0] CYC_LAST = 2'h3; // four clocks per instruction cycle

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_FLUSH = 4'b0010,
    ST_SAVE = 4'b0100,
    ST_VECT = 4'b1000
  } mie_state_e;

  // context copied to the shadow store on entry
  typedef struct packed {
    logic [7:0] w;
    logic [4:0] status;
    logic [4:0] bsr;
    logic [6:0] pclath;
    logic [15:0] fsr0;
    logic [15:0] fsr1;
  } mie_ctx_s;
endpackage : mie_pkg

// *** verilog/mie_shadow_mem.sv ***
`timescale 1ns/100ps
module mie_shadow_mem (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // write side
  input wire logic we,
  input wire mie_pkg::mie_ctx_s wdata,
  // read side, data one cycle after re
  input wire logic re,
  output mie_pkg::mie_ctx_s rdata
);
  import mie_pkg::*;

  mie_ctx_s store;

  // single shadow slot; entry clears the global enable, so nesting needs software to set it again
  always_ff @(posedge clk) begin
    if (rst) begin
      store <= '0;
    end else if (we) begin
      store <= wdata;
    end
  end

  // registered read port
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= '0;
    end else if (re) begin
      rdata <= store;
    end
  end
endmodule : mie_shadow_mem

// *** verilog/mie_irq_entry.sv ***
// Decided for this implementation: the strobed register port and the address map.
`timescale 1ns/100ps
module mie_irq_entry (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RST,
  // register port
  input wire logic [2:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  // interrupt sources, one-cycle event pulses
  input wire logic [2:0] CORE_EVT,
  input wire logic [7:0] PERIPH_EVT1,
  input wire logic [7:0] PERIPH_EVT2,
  // core sequencer
  input wire logic [mie_pkg::PC_W-1:0] CORE_PC,
  input wire mie_pkg::mie_ctx_s CTX_IN,
  input wire logic RET_INSTR,
  output logic IRQ_REQ,
  output logic FLUSH,
  output logic PUSH,
  output logic [mie_pkg::PC_W-1:0] PUSH_PC,
  output logic PC_LOAD,
  output logic [mie_pkg::PC_W-1:0] PC_VEC,
  output logic POP,
  output mie_pkg::mie_ctx_s CTX_OUT,
  output logic CTX_VALID,
  // interrupt output
  output logic IRQ
);
  import mie_pkg::*;

  // any set flag that is also enabled
  function automatic logic gated_any(input logic [7:0] f, input logic [7:0] e);
    return |(f & e);
  endfunction : gated_any

  logic [7:0] irq_control_register;
  logic [7:0] peripheral_flag_register_1;
  logic [7:0] peripheral_flag_register_2;
  logic [7:0] peripheral_enable_reg_1;
  logic [7:0] peripheral_enable_reg_2;
  logic [EVT_W-1:0] evt_stat;
  logic [EVT_W-1:0] evt_mask;
  mie_state_e state;
  mie_state_e next_state;
  logic [1:0] cyc_cnt;
  logic ret_pend;
  mie_ctx_s sh_rdata;

  // ==========================================================
  // register decode
  wire wr_ctrl = WR && (ADDR == OFS_CTRL);
  wire wr_pflag1 = WR && (ADDR == OFS_PFLAG1);
  wire wr_pflag2 = WR && (ADDR == OFS_PFLAG2);
  wire wr_pen1 = WR && (ADDR == OFS_PEN1);
  wire wr_pen2 = WR && (ADDR == OFS_PEN2);
  wire wr_stat = WR && (ADDR == OFS_EVT_STAT);
  wire wr_mask = WR && (ADDR == OFS_EVT_MASK);

  // ==========================================================
  // request combine
  wire global_irq_enable = irq_control_register[CTRL_GIE_BIT];
  wire peripheral_group_irq_enable = irq_control_register[CTRL_PERIPHERAL_GROUP_IRQ_ENABLE_BIT];
  wire [NUM_CORE_SRC-1:0] core_flags = irq_control_register[CTRL_FLAG_LSB +: NUM_CORE_SRC];
  wire [NUM_CORE_SRC-1:0] core_ens = irq_control_register[CTRL_EN_LSB +: NUM_CORE_SRC];
  wire periph_any = gated_any(peripheral_flag_register_1, peripheral_enable_reg_1)
                  | gated_any(peripheral_flag_register_2, peripheral_enable_reg_2);
  wire src_any = (|(core_flags & core_ens)) | (peripheral_group_irq_enable & periph_any);
  wire req_comb = global_irq_enable & src_any;
  wire cyc_en = (cyc_cnt == CYC_LAST);
  // entry starts only on an instruction boundary from idle
  wire take = (state == ST_IDLE) && cyc_en && req_comb;
  wire save_now = (state == ST_FLUSH) && cyc_en;
  wire vect_now = (state == ST_SAVE) && cyc_en;
  wire held_evt = src_any && !global_irq_enable;

  // ==========================================================
  // next values of the control and flag registers
  // hardware set wins over a software clear in the same cycle
  wire [NUM_CORE_SRC-1:0] next_core_flags =
    (wr_ctrl ? WDATA[CTRL_FLAG_LSB +: NUM_CORE_SRC] : core_flags) | CORE_EVT;
  wire [NUM_CORE_SRC-1:0] next_core_ens =
    wr_ctrl ? WDATA[CTRL_EN_LSB +: NUM_CORE_SRC] : core_ens;
  wire next_peripheral_group_irq_enable = wr_ctrl ? WDATA[CTRL_PERIPHERAL_GROUP_IRQ_ENABLE_BIT] : peripheral_group_irq_enable;
  // entry clear beats return set, which beats a software write
  wire next_gie = take ? 1'b0 :
                  RET_INSTR ? 1'b1 :
                  wr_ctrl ? WDATA[CTRL_GIE_BIT] : global_irq_enable;
  wire [7:0] next_ctrl = {next_gie, next_peripheral_group_irq_enable, next_core_ens, next_core_flags};
  wire [7:0] next_pflag1 =
    (wr_pflag1 ? WDATA : peripheral_flag_register_1) | PERIPH_EVT1;
  wire [7:0] next_pflag2 =
    (wr_pflag2 ? WDATA : peripheral_flag_register_2) | PERIPH_EVT2;
  wire [EVT_W-1:0] evt_set = {held_evt, RET_INSTR, take};
  wire [EVT_W-1:0] evt_clr = wr_stat ? WDATA[EVT_W-1:0] : '0;
  wire [EVT_W-1:0] next_evt_stat = (evt_stat & ~evt_clr) | evt_set;

  // read select; unmapped index reads zero
  wire [7:0] rd_mux =
    (ADDR == OFS_CTRL) ? irq_control_register :
    (ADDR == OFS_PFLAG1) ? peripheral_flag_register_1 :
    (ADDR == OFS_PFLAG2) ? peripheral_flag_register_2 :
    (ADDR == OFS_PEN1) ? peripheral_enable_reg_1 :
    (ADDR == OFS_PEN2) ? peripheral_enable_reg_2 :
    (ADDR == OFS_EVT_STAT) ? {5'h00, evt_stat} :
    (ADDR == OFS_EVT_MASK) ? {5'h00, evt_mask} : 8'h00;

  // ==========================================================
  // instruction cycle divider
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      cyc_cnt <= 2'h0;
    end else begin
      cyc_cnt <= cyc_cnt + 2'h1;
    end
  end

  // ==========================================================
  // registers; reset leaves every enable clear
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      irq_control_register <= CTRL_RST;
      peripheral_flag_register_1 <= PREG_RST;
      peripheral_flag_register_2 <= PREG_RST;
      peripheral_enable_reg_1 <= PREG_RST;
      peripheral_enable_reg_2 <= PREG_RST;
    end else begin
      irq_control_register <= next_ctrl;
      peripheral_flag_register_1 <= next_pflag1;
      peripheral_flag_register_2 <= next_pflag2;
      peripheral_enable_reg_1 <= wr_pen1 ? WDATA : peripheral_enable_reg_1;
      peripheral_enable_reg_2 <= wr_pen2 ? WDATA : peripheral_enable_reg_2;
    end
  end

  // sticky event status and mask
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      evt_stat <= EVT_RST;
      evt_mask <= EVT_RST;
    end else begin
      evt_stat <= next_evt_stat;
      evt_mask <= wr_mask ? WDATA[EVT_W-1:0] : evt_mask;
    end
  end

  // ==========================================================
  // entry sequencer, one step per instruction cycle
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (take) begin
          next_state = ST_FLUSH;
        end
      end
      ST_FLUSH: begin
        if (cyc_en) begin
          next_state = ST_SAVE;
        end
      end
      ST_SAVE: begin
        if (cyc_en) begin
          next_state = ST_VECT;
        end
      end
      ST_VECT: begin
        if (cyc_en) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================
  // core strobes; FLUSH, PUSH and PC_LOAD one clock long, POP and CTX_VALID as long as RET_INSTR
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      FLUSH <= 1'b0;
      PUSH <= 1'b0;
      PC_LOAD <= 1'b0;
      POP <= 1'b0;
      ret_pend <= 1'b0;
      CTX_VALID <= 1'b0;
    end else begin
      FLUSH <= take;
      PUSH <= save_now;
      PC_LOAD <= vect_now;
      POP <= RET_INSTR;
      ret_pend <= RET_INSTR;
      CTX_VALID <= ret_pend;
    end
  end

  // core data outputs
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      PUSH_PC <= '0;
      PC_VEC <= VECTOR_ADDR;
      CTX_OUT <= '0;
    end else begin
      PUSH_PC <= save_now ? CORE_PC : PUSH_PC;
      PC_VEC <= VECTOR_ADDR;
      CTX_OUT <= ret_pend ? sh_rdata : CTX_OUT;
    end
  end

  // register read data and interrupt lines
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      RDATA <= 8'h00;
      IRQ_REQ <= 1'b0;
      IRQ <= 1'b0;
    end else begin
      RDATA <= RD ? rd_mux : 8'h00;
      IRQ_REQ <= req_comb;
      IRQ <= |(evt_stat & evt_mask);
    end
  end

  // ==========================================================
  // shadow store: saved with the push, read back on return
  mie_shadow_mem u_shadow (
    .clk(SYS_CLK),
    .rst(RST),
    .we(save_now),
    .wdata(CTX_IN),
    .re(RET_INSTR),
    .rdata(sh_rdata)
  );

  // ==========================================================
  // checks
  // all but the reset check are off while reset is high
  chk_reset_disables: assert property (@(posedge SYS_CLK)
    RST |=> !global_irq_enable && !IRQ_REQ && (state == ST_IDLE))
    else $error("reset left interrupts enabled");

  chk_vector_gated: assert property (@(posedge SYS_CLK) disable iff (RST)
    FLUSH |-> $past(global_irq_enable) && $past(src_any))
    else $error("entry without enables");

  chk_flag_sets: assert property (@(posedge SYS_CLK) disable iff (RST)
    PERIPH_EVT1[0] |=> peripheral_flag_register_1[0])
    else $error("event did not set its flag");

  chk_flush_clears_gie: assert property (@(posedge SYS_CLK) disable iff (RST)
    FLUSH |-> !global_irq_enable && (state == ST_FLUSH))
    else $error("flush without global enable clear");

  chk_push_pc: assert property (@(posedge SYS_CLK) disable iff (RST)
    save_now |=> PUSH && (PUSH_PC == $past(CORE_PC)))
    else $error("pc not pushed");

  chk_shadow_save: assert property (@(posedge SYS_CLK) disable iff (RST)
    PUSH |-> (($past(state) == ST_FLUSH) && (u_shadow.store == $past(CTX_IN))) ##4 PC_LOAD)
    else $error("shadow save out of order");

  chk_vector_load: assert property (@(posedge SYS_CLK) disable iff (RST)
    PC_LOAD |-> (PC_VEC == VECTOR_ADDR) && (state == ST_VECT))
    else $error("wrong vector load");

  chk_no_vector_off: assert property (@(posedge SYS_CLK) disable iff (RST)
    (!global_irq_enable && (state == ST_IDLE)) |=> !FLUSH)
    else $error("vectored with global enable clear");

  chk_return_restores: assert property (@(posedge SYS_CLK) disable iff (RST)
    (RET_INSTR && !take) |=> POP && global_irq_enable ##1 CTX_VALID)
    else $error("return sequence broken");

  chk_pending_taken: assert property (@(posedge SYS_CLK) disable iff (RST)
    ($rose(global_irq_enable) && src_any && (state == ST_IDLE)) |-> ##[0:4] FLUSH)
    else $error("pending interrupt not taken");

  chk_entry_latency: assert property (@(posedge SYS_CLK) disable iff (RST)
    FLUSH |-> ##8 PC_LOAD)
    else $error("entry latency wrong");

  chk_request_or: assert property (@(posedge SYS_CLK) disable iff (RST)
    IRQ_REQ == $past(req_comb))
    else $error("request not the gated or");

  chk_core_flag_sets: assert property (@(posedge SYS_CLK) disable iff (RST)
    (CORE_EVT != 3'h0) |=> ((core_flags & $past(CORE_EVT)) == $past(CORE_EVT)))
    else $error("core event did not set its flag");

  chk_pflag2_sets: assert property (@(posedge SYS_CLK) disable iff (RST)
    (PERIPH_EVT2 != 8'h00) |=> ((peripheral_flag_register_2 & $past(PERIPH_EVT2)) == $past(PERIPH_EVT2)))
    else $error("peripheral event did not set its flag");

  chk_group_gate: assert property (@(posedge SYS_CLK) disable iff (RST)
    (!peripheral_group_irq_enable && ((core_flags & core_ens) == 3'h0)) |=> !IRQ_REQ)
    else $error("request without group enable");

  chk_entry_status: assert property (@(posedge SYS_CLK) disable iff (RST)
    take |=> FLUSH && !global_irq_enable && evt_stat[EVT_ENTRY])
    else $error("entry did not clear global enable");

  chk_busy_no_take: assert property (@(posedge SYS_CLK) disable iff (RST)
    FLUSH |=> (state != ST_IDLE) [*8])
    else $error("entry sequence cut short");

  chk_held_status: assert property (@(posedge SYS_CLK) disable iff (RST)
    held_evt |=> evt_stat[EVT_HELD])
    else $error("held source not recorded");

  chk_restore_data: assert property (@(posedge SYS_CLK) disable iff (RST)
    CTX_VALID |-> $past(POP) && (CTX_OUT == $past(sh_rdata)))
    else $error("context not restored from shadow");

  chk_gie_write: assert property (@(posedge SYS_CLK) disable iff (RST)
    (wr_ctrl && !take && !RET_INSTR) |=> (global_irq_enable == $past(WDATA[CTRL_GIE_BIT])))
    else $error("global enable not at bit 7");
endmodule : mie_irq_entry

// *** tb/mie_core_model.sv ***
`timescale 1ns/100ps
// ==========================================================
// core sequencer stand-in: one-deep return stack, clobbers context in the handler
module mie_core_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // bench commands
  input wire logic load,
  input wire logic [mie_pkg::PC_W-1:0] load_pc,
  input wire mie_pkg::mie_ctx_s load_ctx,
  input wire logic ret_cmd,
  // strobes from the block
  input wire logic push,
  input wire logic [mie_pkg::PC_W-1:0] push_pc,
  input wire logic pc_load,
  input wire logic [mie_pkg::PC_W-1:0] pc_vec,
  input wire logic pop,
  input wire mie_pkg::mie_ctx_s ctx_out,
  input wire logic ctx_valid,
  // core state
  output logic [mie_pkg::PC_W-1:0] core_pc,
  output mie_pkg::mie_ctx_s ctx_in,
  output logic ret_instr
);
  import mie_pkg::*;
  logic [PC_W-1:0] stack_pc;
  // handler scribbles on the context so a missing restore shows up
  always_ff @(posedge clk) begin
    if (rst) begin
      core_pc <= '0;
      ctx_in <= '0;
      ret_instr <= 1'b0;
      stack_pc <= '0;
    end else begin
      ret_instr <= ret_cmd;
      if (load) begin
        core_pc <= load_pc;
        ctx_in <= load_ctx;
      end
      if (push) stack_pc <= push_pc;
      if (pc_load) begin
        core_pc <= pc_vec;
        ctx_in <= ~ctx_in;
      end
      if (pop) core_pc <= stack_pc;
      if (ctx_valid) ctx_in <= ctx_out;
    end
  end
endmodule : mie_core_model

// *** tb/mcu_interrupt_entry_control_test.sv ***
`timescale 1ns/100ps
module mcu_interrupt_entry_control_test;
  import mie_pkg::*;
  // ==========================================================
  // signals
  logic sys_clk, rst, wr, rd, rd_q, irq_req, flush, push, pc_load, pop, ctx_valid, irq;
  logic ld, ret_cmd, ret_instr;
  logic [2:0] addr, core_evt;
  logic [7:0] wdata, rdata, pevt1, pevt2, e1, e2;
  logic [PC_W-1:0] core_pc, push_pc, pc_vec, ld_pc, pc;
  mie_ctx_s ctx_in, ctx_out, ld_ctx, ctx;
  logic [63:0] notes[$];
  logic [63:0] seen, r64;
  integer fails, tests_run, flushes, seed, n;

  mie_irq_entry u_dut (.SYS_CLK(sys_clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .CORE_EVT(core_evt), .PERIPH_EVT1(pevt1), .PERIPH_EVT2(pevt2),
    .CORE_PC(core_pc), .CTX_IN(ctx_in), .RET_INSTR(ret_instr), .IRQ_REQ(irq_req),
    .FLUSH(flush), .PUSH(push), .PUSH_PC(push_pc), .PC_LOAD(pc_load), .PC_VEC(pc_vec),
    .POP(pop), .CTX_OUT(ctx_out), .CTX_VALID(ctx_valid), .IRQ(irq));
  mie_core_model u_core (.clk(sys_clk), .rst(rst), .load(ld), .load_pc(ld_pc),
    .load_ctx(ld_ctx), .ret_cmd(ret_cmd), .push(push), .push_pc(push_pc),
    .pc_load(pc_load), .pc_vec(pc_vec), .pop(pop), .ctx_out(ctx_out),
    .ctx_valid(ctx_valid), .core_pc(core_pc), .ctx_in(ctx_in), .ret_instr(ret_instr));

  // ==========================================================
  // clock and hang guard
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  initial begin
    #2000000;
    fails = fails + 1;
    wrap_up();
  end

  // ==========================================================
  // helpers
  task automatic check(input logic [63:0] s, input logic [63:0] e);
    tests_run = tests_run + 1;
    if (s !== e) begin
      fails = fails + 1;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : check
  task automatic wrap_up();
    if (notes.size() != 0) fails = fails + 1;
    $display("compares %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : wrap_up
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask : wr_reg
  // the note goes in before the strobe so the watcher always finds it
  task automatic rd_reg(input logic [2:0] a, input logic [7:0] e);
    notes.push_back({56'h0, e});
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
  endtask : rd_reg
  task automatic pulse(input logic [2:0] c, input logic [7:0] p1, input logic [7:0] p2);
    @(posedge sys_clk);
    core_evt <= c;
    pevt1 <= p1;
    pevt2 <= p2;
    @(posedge sys_clk);
    core_evt <= '0;
    pevt1 <= '0;
    pevt2 <= '0;
  endtask : pulse
  task automatic ret_now();
    notes.push_back({7'h0, ctx});
    @(posedge sys_clk);
    ret_cmd <= 1'b1;
    @(posedge sys_clk);
    ret_cmd <= 1'b0;
  endtask : ret_now
  // which=0 waits for the vector load, which=1 for the restored context
  task automatic wait_on(input int which, input int lim);
    int cnt;
    for (cnt = 1; cnt <= lim; cnt++) begin
      @(posedge sys_clk);
      #1;
      if ((which == 1 ? ctx_valid : pc_load) === 1'b1) break;
    end
    if (cnt > lim) begin
      fails = fails + 1;
      wrap_up();
    end
  endtask : wait_on
  task automatic entry_notes();
    notes.push_back({49'h0, pc});
    notes.push_back({49'h0, VECTOR_ADDR});
  endtask : entry_notes

  // ==========================================================
  // watcher: every result takes the oldest note
  always @(posedge sys_clk) begin
    if (flush === 1'b1) flushes = flushes + 1;
    if (rd_q || push === 1'b1 || pc_load === 1'b1 || ctx_valid === 1'b1) begin
      seen = rd_q ? {56'h0, rdata} : push === 1'b1 ? {49'h0, push_pc} :
        pc_load === 1'b1 ? {49'h0, pc_vec} : {7'h0, ctx_out};
      check(seen, notes.size() > 0 ? notes.pop_front() : ~seen);
    end
    rd_q <= rd;
  end

  // ==========================================================
  // main sequence
  initial begin
    seed = 32'hD37DEDF1;
    {fails, tests_run, flushes} = '0;
    {rst, wr, rd, rd_q, ld, ret_cmd} = 6'h20;
    {addr, wdata, core_evt, pevt1, pevt2, ld_pc, ld_ctx} = '0;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    for (n = 0; n < 8; n++) rd_reg(n[2:0], 8'h00);
    check({irq_req, irq, pc_vec}, {2'h0, VECTOR_ADDR});
    $display("reset test done");
    // flags set with every enable off
    e1 = 8'($random(seed));
    e2 = 8'($random(seed));
    pulse(e1[2:0], e1, e2);
    rd_reg(3'h0, {5'h0, e1[2:0]});
    rd_reg(3'h1, e1);
    rd_reg(3'h2, e2);
    check(flushes, 0);
    for (n = 0; n < 3; n++) wr_reg(n[2:0], 8'h00);
    // one enable missing in each case: no request
    for (n = 0; n < 3; n++) begin
      wr_reg(3'h3, n == 2 ? 8'h00 : 8'hFF);
      wr_reg(3'h0, n == 0 ? 8'h40 : n == 1 ? 8'h80 : 8'hC0);
      pulse(3'h0, e1 | 8'h01, 8'h00);
      repeat (6) @(posedge sys_clk);
      check({irq_req, flushes}, 0);
      wr_reg(3'h0, 8'h00);
      wr_reg(3'h1, 8'h00);
    end
    $display("gating test done");
    // entry through a peripheral source
    r64 = {$random(seed), $random(seed)};
    ctx = r64[56:0];
    pc = 15'($random(seed));
    @(posedge sys_clk);
    {ld, ld_pc, ld_ctx} <= {1'b1, pc, ctx};
    @(posedge sys_clk);
    ld <= 1'b0;
    wr_reg(3'h6, 8'h07);
    wr_reg(3'h4, 8'h01 << e2[2:0]);
    wr_reg(3'h0, 8'hC8);
    entry_notes();
    pulse(3'h0, 8'h00, 8'h01 << e2[2:0]);
    @(posedge sys_clk);
    #1;
    check(irq_req, 1'b1);
    wait_on(0, 16);
    // the core model takes the vector one edge after the load strobe
    @(posedge sys_clk);
    #1;
    check({core_pc, flushes, irq}, {VECTOR_ADDR, 32'd1, 1'b1});
    rd_reg(3'h0, 8'h48);
    pulse(3'h1, 8'h00, 8'h00);
    repeat (8) @(posedge sys_clk);
    rd_reg(3'h0, 8'h49);
    check(flushes, 1);
    wr_reg(3'h2, 8'h00);
    ret_now();
    wait_on(1, 4);
    @(posedge sys_clk);
    #1;
    check({core_pc, ctx_in}, {pc, ctx});
    $display("entry test done");
    // the flag left pending is taken once global enable is back
    entry_notes();
    wait_on(0, 16);
    check(flushes, 2);
    wr_reg(3'h0, 8'h48);
    ret_now();
    wait_on(1, 4);
    repeat (16) @(posedge sys_clk);
    check(flushes, 2);
    rd_reg(3'h0, 8'hC8);
    rd_reg(3'h5, 8'h07);
    wr_reg(3'h5, 8'h07);
    repeat (2) @(posedge sys_clk);
    check(irq, 0);
    $display("pending test done");
    // reset in mid-run drops every enable
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    rd_reg(3'h0, 8'h00);
    check({irq_req, irq, flush}, 3'h0);
    repeat (2) @(posedge sys_clk);
    $display("second reset test done");
    wrap_up();
  end
endmodule : mcu_interrupt_entry_control_test
